// ---- hdl/test_port_and_io_control.sv ----
// Behaviour
// - Device reset low resets every framer and line unit through core_reset_n.
// - I/O enable and test reset both low float all digital pins.
// - I/O enable high lets digital pins operate normally.
// - Test reset low clears the test port controller asynchronously.
// - Test reset high selects boundary scan mode from the first rising test clock after release.
// - Test reset low leaves scan and resumes normal operation.
// - Mode select sampled on rising test clock steps the state machine.
// - Data and instructions captured from data in on rising edge.
// - Data out changes on the falling test clock edge.
`timescale 1ns/1ps
module test_port_and_io_control
   import test_port_pkg::*;
(
   input  wire logic mclk,               // Core clock, 25 MHz
   input  wire logic resetn,             // Core reset, active low
   input  wire logic device_reset_n,     // Device reset pin
   input  wire logic digital_io_enable,  // Digital I/O enable pin
   input  wire logic test_clock,         // Test clock
   input  wire logic test_port_reset_n,  // Test port reset pin
   input  wire logic test_mode_select,   // Test mode select
   input  wire logic test_data_in,       // Test data in
   output logic      test_data_out,      // Test data out value
   output logic      test_data_out_oe,   // Test data out enable
   output logic      core_reset_n,       // Reset to framers and units
   output logic      digital_io_oe_n,    // Float all digital pins
   output logic      scan_active         // Boundary scan owns the pins
);

   // ==========================================================
   // Link-side test access port
   tap_s tap;
   tap_s next_tap;
   tdo_s tdo;
   tdo_s next_tdo;
   logic [1:0] dev_sync;
   logic [1:0] next_dev_sync;

   // ==========================================================
   // Controller step on one mode select sample
   function automatic tap_state_e tap_step(tap_state_e s, logic tms);
      unique case (s)
         TAP_RESET: begin
            if (tms) begin
               tap_step = TAP_RESET;
            end else begin
               tap_step = TAP_IDLE;
            end
         end

         TAP_IDLE: begin
            if (tms) begin
               tap_step = TAP_SEL_DR;
            end else begin
               tap_step = TAP_IDLE;
            end
         end

         TAP_SEL_DR: begin
            if (tms) begin
               tap_step = TAP_SEL_IR;
            end else begin
               tap_step = TAP_CAP_DR;
            end
         end

         TAP_CAP_DR: begin
            if (tms) begin
               tap_step = TAP_EXIT1_DR;
            end else begin
               tap_step = TAP_SHIFT_DR;
            end
         end

         TAP_SHIFT_DR: begin
            if (tms) begin
               tap_step = TAP_EXIT1_DR;
            end else begin
               tap_step = TAP_SHIFT_DR;
            end
         end

         TAP_EXIT1_DR: begin
            if (tms) begin
               tap_step = TAP_UPD_DR;
            end else begin
               tap_step = TAP_PAUSE_DR;
            end
         end

         TAP_PAUSE_DR: begin
            if (tms) begin
               tap_step = TAP_EXIT2_DR;
            end else begin
               tap_step = TAP_PAUSE_DR;
            end
         end

         TAP_EXIT2_DR: begin
            if (tms) begin
               tap_step = TAP_UPD_DR;
            end else begin
               tap_step = TAP_SHIFT_DR;
            end
         end

         TAP_UPD_DR: begin
            if (tms) begin
               tap_step = TAP_SEL_DR;
            end else begin
               tap_step = TAP_IDLE;
            end
         end

         TAP_SEL_IR: begin
            if (tms) begin
               tap_step = TAP_RESET;
            end else begin
               tap_step = TAP_CAP_IR;
            end
         end

         TAP_CAP_IR: begin
            if (tms) begin
               tap_step = TAP_EXIT1_IR;
            end else begin
               tap_step = TAP_SHIFT_IR;
            end
         end

         TAP_SHIFT_IR: begin
            if (tms) begin
               tap_step = TAP_EXIT1_IR;
            end else begin
               tap_step = TAP_SHIFT_IR;
            end
         end

         TAP_EXIT1_IR: begin
            if (tms) begin
               tap_step = TAP_UPD_IR;
            end else begin
               tap_step = TAP_PAUSE_IR;
            end
         end

         TAP_PAUSE_IR: begin
            if (tms) begin
               tap_step = TAP_EXIT2_IR;
            end else begin
               tap_step = TAP_PAUSE_IR;
            end
         end

         TAP_EXIT2_IR: begin
            if (tms) begin
               tap_step = TAP_UPD_IR;
            end else begin
               tap_step = TAP_SHIFT_IR;
            end
         end

         TAP_UPD_IR: begin
            if (tms) begin
               tap_step = TAP_SEL_DR;
            end else begin
               tap_step = TAP_IDLE;
            end
         end
      endcase
   endfunction

   // Identification register selected by the instruction
   function automatic logic id_selected(logic [IR_W-1:0] ir);
      id_selected = (ir == INSTR_IDCODE);
   endfunction

   // Shift states own the data out pin
   function automatic logic in_shift(tap_state_e s);
      in_shift = (s == TAP_SHIFT_DR) || (s == TAP_SHIFT_IR);
   endfunction

   always_comb begin
      next_tap = tap;
      next_tap.state = tap_step(tap.state, test_mode_select);
      // Scan mode holds from the first clock after release
      next_tap.scan_mode = 1'b1;
      unique case (tap.state)
         TAP_CAP_IR: begin
            next_tap.ir_shift = IR_CAPTURE;
         end

         TAP_SHIFT_IR: begin
            next_tap.ir_shift =
               {test_data_in, tap.ir_shift[IR_W-1:1]};
         end

         TAP_UPD_IR: begin
            next_tap.ir = tap.ir_shift;
         end

         TAP_CAP_DR: begin
            if (id_selected(tap.ir)) begin
               next_tap.dr_shift = ID_CODE;
            end else begin
               next_tap.dr_shift = '0;
            end
         end

         TAP_SHIFT_DR: begin
            if (id_selected(tap.ir)) begin
               next_tap.dr_shift =
                  {test_data_in, tap.dr_shift[ID_W-1:1]};
            end else begin
               // Bypass and other codes: one-bit path
               next_tap.dr_shift = {{(ID_W-1){1'b0}}, test_data_in};
            end
         end

         TAP_RESET: begin
            next_tap.ir = INSTR_IDCODE;
         end

         default: ;
      endcase
   end

   // Reset state of the test port selects identification
   always_ff @(posedge test_clock or negedge test_port_reset_n) begin
      if (!test_port_reset_n) begin
         tap <= '{state: TAP_RESET, ir_shift: '0, ir: INSTR_IDCODE,
                  dr_shift: '0, scan_mode: 1'b0};
      end else begin
         tap <= next_tap;
      end
   end

   // ==========================================================
   // Falling-edge data out
   always_comb begin
      next_tdo.tdo_oe = in_shift(tap.state);
      if (tap.state == TAP_SHIFT_IR) begin
         next_tdo.tdo = tap.ir_shift[0];
      end else begin
         next_tdo.tdo = tap.dr_shift[0];
      end
   end

   always_ff @(negedge test_clock or negedge test_port_reset_n) begin
      if (!test_port_reset_n) begin
         tdo <= '0;
      end else begin
         tdo <= next_tdo;
      end
   end

   assign test_data_out    = tdo.tdo;
   assign test_data_out_oe = tdo.tdo_oe;

   // ==========================================================
   // Core side: pin synchronisers
   core_s core;
   core_s next_core;

   always_comb begin
      // Scan flag crosses to the core clock in two flops
      next_core.scan_sync = {core.scan_sync[0], tap.scan_mode};
      next_core.dio_sync  = {core.dio_sync[0], digital_io_enable};
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         core <= '0;
      end else begin
         core <= next_core;
      end
   end

   // Device reset: async assert, synchronous release
   always_comb begin
      next_dev_sync = {dev_sync[0], 1'b1};
   end

   always_ff @(posedge mclk or negedge device_reset_n) begin
      if (!device_reset_n) begin
         dev_sync <= '0;
      end else begin
         dev_sync <= next_dev_sync;
      end
   end

   assign core_reset_n = dev_sync[1] & resetn;
   assign scan_active  = core.scan_sync[1];

   // Float pins while enable low and boundary scan not active
   assign digital_io_oe_n = !core.dio_sync[1] &&
                            !core.scan_sync[1];

endmodule

// ---- hdl/test_port_pkg.sv ----
package test_port_pkg;

   // ==========================================================
   // Test access port states
   typedef enum logic [3:0] {
      TAP_RESET,
      TAP_IDLE,
      TAP_SEL_DR,
      TAP_CAP_DR,
      TAP_SHIFT_DR,
      TAP_EXIT1_DR,
      TAP_PAUSE_DR,
      TAP_EXIT2_DR,
      TAP_UPD_DR,
      TAP_SEL_IR,
      TAP_CAP_IR,
      TAP_SHIFT_IR,
      TAP_EXIT1_IR,
      TAP_PAUSE_IR,
      TAP_EXIT2_IR,
      TAP_UPD_IR
   } tap_state_e;

   // ==========================================================
   // Instruction register
   localparam int unsigned IR_W = 4;
   localparam int unsigned ID_W = 32;
   localparam logic [IR_W-1:0] INSTR_EXTEST = 4'h0;
   localparam logic [IR_W-1:0] INSTR_IDCODE = 4'h1;
   localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hF;
   // Capture pattern of the instruction register
   localparam logic [IR_W-1:0] IR_CAPTURE   = 4'h1;
   // Identification code: value is arbitrary
   localparam logic [ID_W-1:0] ID_CODE      = 32'h0A5A5001;

   // ==========================================================
   // Link-side state
   typedef struct packed {
      tap_state_e      state;
      logic [IR_W-1:0] ir_shift;
      logic [IR_W-1:0] ir;
      logic [ID_W-1:0] dr_shift;
      logic            scan_mode;
   } tap_s;

   // ==========================================================
   // Core-side state
   typedef struct packed {
      logic [1:0] scan_sync;
      logic [1:0] dio_sync;
   } core_s;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
   } tdo_s;

endpackage

// ---- verif/test_port_asserts.sv ----
`timescale 1ns/1ps
module test_port_asserts (
   input wire logic mclk,              // Core clock
   input wire logic resetn,            // Core reset
   input wire logic device_reset_n,    // Device reset
   input wire logic digital_io_enable, // I/O enable
   input wire logic test_clock,        // Test clock
   input wire logic test_port_reset_n, // Test reset
   input wire logic test_mode_select,  // Mode select
   input wire logic test_data_out_oe,  // Data out enable
   input wire logic core_reset_n,      // Unit reset
   input wire logic digital_io_oe_n,   // Pin float
   input wire logic scan_active        // Scan owns pins
);
   // ==========================================
   // Core domain
   sequence s_release;
      !core_reset_n ##[1:2] core_reset_n;
   endsequence
   property p_core_lo;
      @(posedge mclk) disable iff (!resetn) !device_reset_n |-> !core_reset_n;
   endproperty
   a_core_lo: assert property (p_core_lo) else $error("reset held");
   property p_core_rel;
      @(posedge mclk) disable iff (!resetn)
         $rose(device_reset_n) |-> s_release;
   endproperty
   a_core_rel: assert property (p_core_rel) else $error("release");
   property p_float;
      @(posedge mclk) disable iff (!resetn)
         (!digital_io_enable && !test_port_reset_n)[*3] |-> digital_io_oe_n;
   endproperty
   a_float: assert property (p_float) else $error("no float");
   property p_normal;
      @(posedge mclk) disable iff (!resetn)
         digital_io_enable[*3] |-> !digital_io_oe_n;
   endproperty
   a_normal: assert property (p_normal) else $error("floated");
   property p_tap_rst;
      @(posedge mclk) disable iff (!resetn)
         !test_port_reset_n |-> !test_data_out_oe;
   endproperty
   a_tap_rst: assert property (p_tap_rst) else $error("oe in reset");
   property p_scan_off;
      @(posedge mclk) disable iff (!resetn)
         !test_port_reset_n[*3] |-> !scan_active;
   endproperty
   a_scan_off: assert property (p_scan_off) else $error("scan on");
   // ==========================================
   // Test clock domain
   property p_oe_exit;
      @(posedge test_clock) disable iff (!test_port_reset_n)
         test_data_out_oe && test_mode_select |=> !test_data_out_oe;
   endproperty
   a_oe_exit: assert property (p_oe_exit) else $error("oe stuck");
   property p_tms_rst;
      @(posedge test_clock) disable iff (!test_port_reset_n)
         test_mode_select[*5] |=> !test_data_out_oe;
   endproperty
   a_tms_rst: assert property (p_tms_rst) else $error("no reset");
endmodule
bind test_port_and_io_control test_port_asserts chk (.*);

// ---- verif/scan_master.sv ----
`timescale 1ns/1ps
module scan_master (
   input  wire logic test_data_out,    // From device
   input  wire logic test_data_out_oe, // Device drives
   output logic      test_clock,       // Still between frames
   output logic      test_mode_select, // Mode select
   output logic      test_data_in      // Data to device
);
   initial {test_clock, test_mode_select, test_data_in} = 3'h3;
   // One 15 ns test clock period
   task automatic step(input logic m, d, output logic [1:0] q);
      #1 {test_mode_select, test_data_in} = {m, d};
      #6.5 q = {test_data_out_oe, test_data_out};
      test_clock = 1'b1;
      #7.5 test_clock = 1'b0;
   endtask
endmodule

// ---- verif/test_port_and_io_control_tb_top.sv ----
`timescale 1ns/1ps
module test_port_and_io_control_tb_top;
   import test_port_pkg::*;
   logic mclk = 0, resetn = 0, device_reset_n = 0, digital_io_enable = 0;
   logic test_port_reset_n = 0;
   logic test_clock, test_mode_select, test_data_in, test_data_out;
   logic test_data_out_oe, core_reset_n, digital_io_oe_n, scan_active;
   logic [1:0] q;
   logic [31:0] d;
   int bad_count, n_tests, cycles;
   // I/O enable, test reset, expected float
   logic [2:0] rows [4] = '{3'h6, 3'h3, 3'h4, 3'h1};
   test_port_and_io_control dut (.*);
   scan_master m (.*);
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Mode bits and data bits, first bit first
   task automatic run(input logic [31:0] t, din, input int n);
      for (int i = 0; i < n; i++) begin
         m.step(t[i], din[i], q);
         d[i] = q[0];
      end
   endtask
   initial begin
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      @(negedge mclk) device_reset_n = 1'b1;
      foreach (rows[i]) begin
         {digital_io_enable, test_port_reset_n} = rows[i][2:1];
         repeat (4) @(negedge mclk);
         check(digital_io_oe_n, rows[i][0]);
         check(scan_active, 1'b0);
      end
      device_reset_n = 1'b0;
      #1 check(core_reset_n, 1'b0);
      repeat (3) @(negedge mclk);
      device_reset_n = 1'b1;
      repeat (3) @(negedge mclk);
      check(core_reset_n, 1'b1);
      test_port_reset_n = 1'b1;
      run(32'h2, 32'h0, 4);
      run(32'h80000000, 32'h0, 32);
      check(d, ID_CODE);
      run(32'h1, 32'h0, 2);
      check(q[1], 1'b0);
      repeat (3) @(negedge mclk);
      check(scan_active, 1'b1);
      check(digital_io_oe_n, 1'b0);
      run(32'h3, 32'h0, 4);
      run(32'h8, 32'hF, 4);
      check(d[3:0], IR_CAPTURE);
      run(32'h3, 32'h0, 4);
      run(32'h4, 32'h5, 3);
      check(d[2:0], 3'h2);
      run(32'h1F, 32'h0, 5);
      check(q[1], 1'b0);
      run(32'h2, 32'h0, 4);
      #1 check(test_data_out_oe, 1'b1);
      check(test_data_out, ID_CODE[0]);
      @(negedge mclk) test_port_reset_n = 1'b0;
      #1 check(test_data_out_oe, 1'b0);
      repeat (4) @(negedge mclk);
      check(scan_active, 1'b0);
      tally_and_finish();
   end
endmodule
